/* core/rbs_pkg.sv */
// Shared constants and types for the radio baseband symbol path.
package rbs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_HZ          = 10_000_000;
  localparam int unsigned SYMBOL_RATE_HZ    = 62_500;
  localparam int unsigned CHIPS_PER_SYMBOL  = 32;
  localparam int unsigned CYCLES_PER_SYMBOL = CLOCK_HZ / SYMBOL_RATE_HZ;
  localparam int unsigned AGC_CYCLES        = CYCLES_PER_SYMBOL / 4;
  localparam int unsigned RSSI_SYMBOLS      = 8;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SYM_W        = 4;
  localparam int unsigned GAIN_W       = 4;
  localparam int unsigned MAG_W        = 8;
  localparam int unsigned ACC_W        = 16;
  localparam int unsigned FIFO_DEPTH   = 8;
  localparam logic [3:0]  GAIN_RESET   = 4'h8;
  localparam logic [7:0]  MAG_TARGET   = 8'h40;
  localparam logic [4:0]  MATCH_MIN    = 5'h1c;
  localparam logic [2:0]  PREAMBLE_SYM = 3'h4;

  // ----------------------------------------------------------------
  // Receive states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RBS_HUNT,
    RBS_SYNC,
    RBS_PACKET
  } rbs_rx_e;

  // Chip sequences for each symbol, c0 in bit 0.
  localparam logic [31:0] CHIP_TABLE [16] = '{
    32'h744ac39b, 32'h44ac39b7, 32'h4ac39b74, 32'hac39b744,
    32'hc39b744a, 32'h39b744ac, 32'h9b744ac3, 32'hb744ac39,
    32'hdee06931, 32'hee06931d, 32'he06931de, 32'h06931dee,
    32'h6931dee0, 32'h931dee06, 32'h31dee069, 32'h1dee0693
  };

endpackage : rbs_pkg

/* core/rbs_fifo.sv */
// Small valid/ready FIFO holding received symbols.
`timescale 1ns/10ps
module rbs_fifo #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : rbs_fifo

/* core/rbs_baseband.sv */
// Radio baseband symbol path: receive sync, despread, AGC, RSSI, CCA and transmit spread.
`timescale 1ns/10ps
module rbs_baseband (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              chip_in,
  input  wire logic              chip_strobe,
  input  wire logic [7:0]        rx_magnitude,
  input  wire logic              packet_end,
  output logic      [3:0]        rx_gain,
  output logic      [3:0]        rx_symbol,
  output logic                   rx_symbol_valid,
  input  wire logic              rx_symbol_ready,
  output logic                   rx_synced,
  output logic      [7:0]        rssi,
  output logic                   rssi_update,
  input  wire logic [7:0]        cca_threshold,
  input  wire logic              cca_request,
  output logic                   cca_busy,
  output logic                   cca_done,
  input  wire logic              tx_mode,
  input  wire logic [3:0]        tx_symbol,
  input  wire logic              tx_symbol_valid,
  output logic                   tx_symbol_ready,
  output logic                   tx_chip,
  output logic                   tx_chip_valid,
  output logic                   port_c_pin5,
  output logic                   port_c_pin6
);
  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [7:0] mag_s1;
  logic [7:0] mag_s2;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Magnitude bits are sampled loosely; a torn sample only jitters one gain step.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      mag_s1 <= 8'h00;
      mag_s2 <= 8'h00;
    end else begin
      pin_s1 <= {packet_end, chip_strobe, chip_in};
      pin_s2 <= pin_s1;
      mag_s1 <= rx_magnitude;
      mag_s2 <= mag_s1;
    end
  end

  logic chip_d;
  logic strobe_d;
  logic pend_d;
  assign chip_d   = pin_s2[0];
  assign strobe_d = pin_s2[1];
  assign pend_d   = pin_s2[2];

  // ----------------------------------------------------------------
  // Receive: sync, despread and gain
  // ----------------------------------------------------------------
  rbs_pkg::rbs_rx_e state;
  rbs_pkg::rbs_rx_e next_state;
  logic [31:0] shreg;
  logic [31:0] next_shreg;
  logic [4:0]  chip_cnt;
  logic [4:0]  next_chip_cnt;
  logic [2:0]  pre_cnt;
  logic [2:0]  next_pre_cnt;
  logic [3:0]  gain;
  logic [3:0]  next_gain;
  logic [7:0]  agc_cnt;
  logic [7:0]  next_agc_cnt;
  logic [3:0]  best_sym;
  logic [5:0]  best_score;
  logic [3:0]  sym_q;
  logic        sym_push;
  logic        fifo_ready;
  logic [31:0] window;

  assign window = {chip_d, shreg[31:1]};

  always_comb begin
    logic [5:0] score;
    score      = 6'h00;
    best_sym   = 4'h0;
    best_score = 6'h00;
    for (int s = 0; s < 16; s++) begin
      score = 6'($countones(~(window ^ rbs_pkg::CHIP_TABLE[s])));
      if (score > best_score) begin
        best_score = score;
        best_sym   = 4'(s);
      end
    end
  end

  always_comb begin
    next_state    = state;
    next_shreg    = shreg;
    next_chip_cnt = chip_cnt;
    next_pre_cnt  = pre_cnt;
    next_gain     = gain;
    next_agc_cnt  = agc_cnt;
    sym_push      = 1'b0;
    if (state != rbs_pkg::RBS_PACKET) begin
      if (agc_cnt == 8'(rbs_pkg::AGC_CYCLES - 1)) begin
        next_agc_cnt = 8'h00;
        if (mag_s2 > rbs_pkg::MAG_TARGET && gain != 4'h0) begin
          next_gain = gain - 4'h1;
        end else if (mag_s2 < rbs_pkg::MAG_TARGET && gain != 4'hf) begin
          next_gain = gain + 4'h1;
        end
      end else begin
        next_agc_cnt = agc_cnt + 8'h01;
      end
    end
    if (strobe_d) begin
      next_shreg = window;
      unique case (state)
        rbs_pkg::RBS_HUNT: begin
          if (best_score >= 6'(rbs_pkg::MATCH_MIN) && best_sym == 4'h0) begin
            next_state    = rbs_pkg::RBS_SYNC;
            next_chip_cnt = 5'h00;
            next_pre_cnt  = 3'h1;
          end
        end
        rbs_pkg::RBS_SYNC: begin
          next_chip_cnt = chip_cnt + 5'h01;
          if (chip_cnt == 5'h1f) begin
            if (best_sym != 4'h0 || best_score < 6'(rbs_pkg::MATCH_MIN)) begin
              next_state = rbs_pkg::RBS_HUNT;
            end else if (pre_cnt == rbs_pkg::PREAMBLE_SYM - 3'h1) begin
              next_state = rbs_pkg::RBS_PACKET;
            end else begin
              next_pre_cnt = pre_cnt + 3'h1;
            end
          end
        end
        rbs_pkg::RBS_PACKET: begin
          next_chip_cnt = chip_cnt + 5'h01;
          if (chip_cnt == 5'h1f) begin
            sym_push = 1'b1;
          end
        end
      endcase
    end
    if (pend_d) begin
      next_state = rbs_pkg::RBS_HUNT;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state    <= rbs_pkg::RBS_HUNT;
      shreg    <= 32'h00000000;
      chip_cnt <= 5'h00;
      pre_cnt  <= 3'h0;
      gain     <= rbs_pkg::GAIN_RESET;
      agc_cnt  <= 8'h00;
      sym_q    <= 4'h0;
    end else begin
      state    <= next_state;
      shreg    <= next_shreg;
      chip_cnt <= next_chip_cnt;
      pre_cnt  <= next_pre_cnt;
      gain     <= next_gain;
      agc_cnt  <= next_agc_cnt;
      sym_q    <= best_sym;
    end
  end

  // A full FIFO drops the symbol; the MAC must drain at least at the symbol rate.
  logic       push_q;
  logic [3:0] fifo_data;
  logic       fifo_valid;
  logic       fifo_pop;
  assign fifo_pop = fifo_valid && (!rx_symbol_valid || rx_symbol_ready);

  rbs_fifo #(
    .WIDTH (rbs_pkg::SYM_W),
    .DEPTH (rbs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_data   (sym_q),
    .in_valid  (push_q),
    .in_ready  (fifo_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ----------------------------------------------------------------
  // Strength, assessment and transmit
  // ----------------------------------------------------------------
  logic [15:0] acc;
  logic [15:0] next_acc;
  logic [16:0] acc_sum;
  logic [7:0]  sym_tick;
  logic [7:0]  next_sym_tick;
  logic [2:0]  sym_cnt;
  logic [2:0]  next_sym_cnt;
  logic [7:0]  next_rssi;
  logic        next_rssi_update;
  logic        next_cca_busy;
  logic [4:0]  tx_idx;
  logic [4:0]  next_tx_idx;
  logic [31:0] tx_seq;
  logic [31:0] next_tx_seq;
  logic        tx_busy;
  logic        next_tx_busy;
  logic [3:0]  next_rx_symbol;
  logic        next_rx_valid;

  // The window sum saturates, so a strong signal never wraps round to read as a weak one.
  assign acc_sum = {1'b0, acc} + 17'(mag_s2);

  always_comb begin
    next_acc         = acc_sum[16] ? 16'hffff : acc_sum[15:0];
    next_sym_tick    = sym_tick + 8'h01;
    next_sym_cnt     = sym_cnt;
    next_rssi        = rssi;
    next_rssi_update = 1'b0;
    if (sym_tick == 8'(rbs_pkg::CYCLES_PER_SYMBOL - 1)) begin
      next_sym_tick = 8'h00;
      next_sym_cnt  = sym_cnt + 3'h1;
    end
    if ((sym_tick == 8'(rbs_pkg::CYCLES_PER_SYMBOL - 1) && sym_cnt == 3'h7) || pend_d) begin
      next_rssi        = acc[15:8];
      next_rssi_update = 1'b1;
      next_acc         = 16'h0000;
      next_sym_tick    = 8'h00;
      next_sym_cnt     = 3'h0;
    end
    next_cca_busy = cca_busy;
    if (cca_request) begin
      next_cca_busy = (rssi > cca_threshold);
    end
    next_tx_idx  = tx_idx;
    next_tx_seq  = tx_seq;
    next_tx_busy = tx_busy;
    if (tx_busy && tx_chip_valid) begin
      next_tx_idx = tx_idx + 5'h01;
      if (tx_idx == 5'h1f) begin
        next_tx_busy = 1'b0;
      end
    end else if (!tx_busy && tx_mode && tx_symbol_valid) begin
      next_tx_seq  = rbs_pkg::CHIP_TABLE[tx_symbol];
      next_tx_idx  = 5'h00;
      next_tx_busy = 1'b1;
    end
    next_rx_symbol = rx_symbol;
    next_rx_valid  = rx_symbol_valid && !rx_symbol_ready;
    if (fifo_pop) begin
      next_rx_symbol = fifo_data;
      next_rx_valid  = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc             <= 16'h0000;
      sym_tick        <= 8'h00;
      sym_cnt         <= 3'h0;
      rssi            <= 8'h00;
      rssi_update     <= 1'b0;
      cca_busy        <= 1'b0;
      cca_done        <= 1'b0;
      tx_idx          <= 5'h00;
      tx_seq          <= 32'h00000000;
      tx_busy         <= 1'b0;
      tx_chip         <= 1'b0;
      tx_chip_valid   <= 1'b0;
      tx_symbol_ready <= 1'b0;
      rx_symbol       <= 4'h0;
      rx_symbol_valid <= 1'b0;
      rx_gain         <= rbs_pkg::GAIN_RESET;
      rx_synced       <= 1'b0;
      push_q          <= 1'b0;
      port_c_pin5     <= 1'b0;
      port_c_pin6     <= 1'b1;
    end else begin
      acc             <= next_acc;
      sym_tick        <= next_sym_tick;
      sym_cnt         <= next_sym_cnt;
      rssi            <= next_rssi;
      rssi_update     <= next_rssi_update;
      cca_busy        <= next_cca_busy;
      cca_done        <= cca_request;
      tx_idx          <= next_tx_idx;
      tx_seq          <= next_tx_seq;
      tx_busy         <= next_tx_busy;
      tx_chip         <= next_tx_seq[next_tx_idx];
      tx_chip_valid   <= next_tx_busy;
      tx_symbol_ready <= !next_tx_busy && tx_mode;
      rx_symbol       <= next_rx_symbol;
      rx_symbol_valid <= next_rx_valid;
      rx_gain         <= next_gain;
      rx_synced       <= (next_state == rbs_pkg::RBS_PACKET);
      push_q          <= sym_push && fifo_ready;
      port_c_pin5     <= tx_mode;
      port_c_pin6     <= !tx_mode;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_gain_frozen: assert property (@(posedge clock) disable iff (!rst_n)
    (state == rbs_pkg::RBS_PACKET && next_state == rbs_pkg::RBS_PACKET) |=> $stable(gain))
    else $error("gain moved during packet");
  a_agc_period: assert property (@(posedge clock) disable iff (!rst_n)
    (gain != $past(gain)) |-> ($past(agc_cnt) == 8'(rbs_pkg::AGC_CYCLES - 1)))
    else $error("gain stepped off the quarter symbol");
  a_pa_complement: assert property (@(posedge clock) disable iff (!rst_n)
    port_c_pin6 == !port_c_pin5)
    else $error("pa outputs not complementary");
  a_pa_follows: assert property (@(posedge clock) disable iff (!rst_n)
    tx_mode |=> port_c_pin5)
    else $error("pa enable not set in transmit");
  a_cca_compare: assert property (@(posedge clock) disable iff (!rst_n)
    cca_request |=> (cca_busy == ($past(rssi) > $past(cca_threshold))) && cca_done)
    else $error("cca result wrong");
  a_rssi_end: assert property (@(posedge clock) disable iff (!rst_n)
    pend_d |=> rssi_update)
    else $error("no strength update at packet end");
  a_sync_first: assert property (@(posedge clock) disable iff (!rst_n)
    sym_push |-> state == rbs_pkg::RBS_PACKET)
    else $error("symbol before sync");
  a_tx_chips: assert property (@(posedge clock) disable iff (!rst_n)
    (!tx_busy && tx_mode && tx_symbol_valid) |=> tx_busy [*8])
    else $error("transmit sequence cut short");
endmodule : rbs_baseband

/* dv/rbs_chip_source.sv */
// Front-end model that plays the chips of one symbol per request.
`timescale 1ns/10ps
module rbs_chip_source (
  input  wire logic       clock,
  input  wire logic       go,
  input  wire logic [3:0] sym,
  output logic            busy,
  output logic            chip_in,
  output logic            chip_strobe
);
  logic [31:0] word;
  logic [7:0]  cnt;

  initial begin
    busy = 1'b0;
    chip_in = 1'b0;
    chip_strobe = 1'b0;
  end

  // Five cycles a chip keeps the symbol rate; the chip line is held two cycles and then
  // toggled each cycle, so a design that samples two or four cycles late sees an inverted chip.
  always @(posedge clock) begin
    if (!busy) begin
      chip_strobe <= 1'b0;
      chip_in     <= ~chip_in;
      if (go) begin
        busy <= 1'b1;
        word <= rbs_pkg::CHIP_TABLE[sym];
        cnt  <= 8'h00;
      end
    end else begin
      chip_strobe <= (cnt % 5 == 0);
      chip_in     <= (cnt % 5 < 2) ? word[cnt / 5] : ~chip_in;
      cnt         <= cnt + 8'h01;
      busy        <= (cnt != 8'h9f);
    end
  end
endmodule : rbs_chip_source

/* dv/rbs_baseband_test.sv */
// Self-checking bench for the radio baseband symbol path.
`timescale 1ns/10ps
module rbs_baseband_test;
  logic       clock, reset_n, chip_in, chip_strobe, src_go, src_busy, packet_end;
  logic       rx_symbol_valid, rx_symbol_ready, rx_synced, rssi_update, cca_request;
  logic       cca_busy, cca_done, tx_mode, tx_symbol_valid, tx_symbol_ready;
  logic       tx_chip, tx_chip_valid, port_c_pin5, port_c_pin6, pre_sync;
  logic [3:0] src_sym, rx_gain, rx_symbol, tx_symbol;
  logic [7:0] rx_magnitude, rssi, cca_threshold;
  logic [3:0] got_q [$];
  int         failures = 0;
  int         num_checks = 0;
  int         cycles = 0;
  int         early = 0;

  rbs_baseband u_rbs_baseband (.clock(clock), .reset_n(reset_n), .chip_in(chip_in),
    .chip_strobe(chip_strobe), .rx_magnitude(rx_magnitude), .packet_end(packet_end),
    .rx_gain(rx_gain), .rx_symbol(rx_symbol), .rx_symbol_valid(rx_symbol_valid),
    .rx_symbol_ready(rx_symbol_ready), .rx_synced(rx_synced), .rssi(rssi),
    .rssi_update(rssi_update), .cca_threshold(cca_threshold), .cca_request(cca_request),
    .cca_busy(cca_busy), .cca_done(cca_done), .tx_mode(tx_mode), .tx_symbol(tx_symbol),
    .tx_symbol_valid(tx_symbol_valid), .tx_symbol_ready(tx_symbol_ready),
    .tx_chip(tx_chip), .tx_chip_valid(tx_chip_valid), .port_c_pin5(port_c_pin5),
    .port_c_pin6(port_c_pin6));

  rbs_chip_source u_rbs_chip_source (.clock(clock), .go(src_go), .sym(src_sym),
    .busy(src_busy), .chip_in(chip_in), .chip_strobe(chip_strobe));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // --------------------
  // Collector and limit
  // --------------------
  always @(posedge clock) begin
    cycles++;
    if (rx_symbol_valid === 1'b1 && rx_symbol_ready === 1'b1) got_q.push_back(rx_symbol);
    if (pre_sync && rx_symbol_valid !== 1'b0) early++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // --------------------
  // Helpers
  // --------------------
  task automatic send_sym(input logic [3:0] s);
    @(posedge clock);
    src_sym <= s;
    src_go  <= 1'b1;
    @(posedge clock);
    src_go  <= 1'b0;
    @(posedge clock);
    while (src_busy) @(posedge clock);
  endtask : send_sym

  task automatic preamble;
    pre_sync <= 1'b1;
    repeat (4) send_sym(4'h0);
    pre_sync <= 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    check("early symbols", 0, early);
    check("synced", 1, rx_synced);
  endtask : preamble

  task automatic next_update(output int n);
    @(negedge clock);
    for (n = 1; n < 1500 && rssi_update !== 1'b1; n++) @(negedge clock);
  endtask : next_update

  task automatic end_packet;
    int n;
    @(posedge clock);
    packet_end <= 1'b1;
    @(posedge clock);
    packet_end <= 1'b0;
    next_update(n);
    check("end update", 1, n < 10);
    repeat (3) @(negedge clock);
    check("synced after end", 0, rx_synced);
  endtask : end_packet

  // --------------------
  // Scenarios
  // --------------------
  task automatic test_agc;
    logic [3:0] g;
    int         n;
    rx_magnitude <= 8'hff;
    @(negedge clock);
    g = rx_gain;
    for (n = 0; n < 100 && rx_gain === g; n++) @(negedge clock);
    g = rx_gain;
    for (n = 0; n < 100 && rx_gain === g; n++) @(negedge clock);
    check("agc period", rbs_pkg::AGC_CYCLES, n);
    check("agc down", g - 4'h1, rx_gain);
    @(posedge clock);
    rx_magnitude <= 8'h00;
    g = rx_gain;
    for (n = 0; n < 100 && rx_gain === g; n++) @(negedge clock);
    check("agc up", g + 4'h1, rx_gain);
  endtask : test_agc

  task automatic test_rx_packet;
    logic [3:0] syms [4] = '{4'h3, 4'h7, 4'ha, 4'hf};
    logic [3:0] g;
    @(posedge clock);
    got_q.delete();
    rx_symbol_ready <= 1'b1;
    rx_magnitude    <= 8'h40;
    preamble();
    g = rx_gain;
    @(posedge clock);
    rx_magnitude <= 8'h00;
    foreach (syms[i]) send_sym(syms[i]);
    repeat (10) @(negedge clock);
    check("gain frozen", g, rx_gain);
    check("rx count", 4, got_q.size());
    foreach (syms[i]) check("rx symbol", syms[i], got_q[i]);
    end_packet();
  endtask : test_rx_packet

  task automatic test_fifo_full;
    @(posedge clock);
    got_q.delete();
    rx_symbol_ready <= 1'b0;
    preamble();
    for (int i = 0; i < 10; i++) send_sym(4'(i + 1));
    @(posedge clock);
    rx_symbol_ready <= 1'b1;
    repeat (20) @(negedge clock);
    check("fifo kept", rbs_pkg::FIFO_DEPTH + 1, got_q.size());
    for (int i = 0; i < 9; i++) check("fifo order", i + 1, got_q[i]);
    end_packet();
  endtask : test_fifo_full

  task automatic test_rssi_cca;
    int         n;
    logic [7:0] thr [4];
    @(posedge clock);
    rx_magnitude <= 8'hff;
    next_update(n);
    next_update(n);
    check("rssi period", rbs_pkg::RSSI_SYMBOLS * rbs_pkg::CYCLES_PER_SYMBOL, n);
    check("rssi level", 8'hff, rssi);
    thr = '{8'h00, 8'hfe, 8'hff, 8'hff};
    foreach (thr[i]) begin
      @(posedge clock);
      cca_threshold <= thr[i];
      cca_request   <= 1'b1;
      @(posedge clock);
      cca_request   <= 1'b0;
      @(negedge clock);
      check("cca done", 1, cca_done);
      check("cca busy", 8'hff > thr[i], cca_busy);
      @(negedge clock);
      check("cca done pulse", 0, cca_done);
    end
  endtask : test_rssi_cca

  task automatic test_tx;
    int n = 0;
    @(posedge clock);
    tx_symbol       <= 4'h5;
    tx_symbol_valid <= 1'b1;
    repeat (40) begin
      @(negedge clock);
      n += int'(tx_chip_valid !== 1'b0);
    end
    check("refused in receive", 0, n);
    @(posedge clock);
    tx_symbol_valid <= 1'b0;
    tx_mode         <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    check("pin5 transmit", 1, port_c_pin5);
    check("pin6 transmit", 0, port_c_pin6);
    for (int s = 0; s < 16; s++) begin
      for (n = 0; n < 50 && tx_symbol_ready !== 1'b1; n++) @(negedge clock);
      check("tx ready", 1, tx_symbol_ready);
      @(posedge clock);
      tx_symbol       <= 4'(s);
      tx_symbol_valid <= 1'b1;
      @(posedge clock);
      tx_symbol_valid <= 1'b0;
      for (int i = 0; i < 32; i++) begin
        @(negedge clock);
        check("chip valid", 1, tx_chip_valid);
        check("chip", rbs_pkg::CHIP_TABLE[s][i], tx_chip);
        if (i < 31) @(posedge clock);
      end
      @(negedge clock);
      check("chip valid end", 0, tx_chip_valid);
    end
    @(posedge clock);
    tx_mode <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    check("pin5 receive", 0, port_c_pin5);
    check("pin6 receive", 1, port_c_pin6);
  endtask : test_tx

  initial begin
    reset_n = 1'b0;
    {src_go, src_sym, packet_end, rx_symbol_ready, cca_request, pre_sync} = '0;
    {tx_mode, tx_symbol, tx_symbol_valid, cca_threshold} = '0;
    rx_magnitude = 8'h40;
    repeat (5) @(posedge clock);
    @(negedge clock);
    check("gain at reset", rbs_pkg::GAIN_RESET, rx_gain);
    check("pin5 at reset", 0, port_c_pin5);
    check("pin6 at reset", 1, port_c_pin6);
    @(posedge clock);
    reset_n <= 1'b1;
    repeat (6) @(posedge clock);
    test_agc();
    test_rx_packet();
    test_fifo_full();
    test_rssi_cca();
    test_tx();
    test_done();
  end
endmodule : rbs_baseband_test
